// ---- rtl/pcb_host.sv ----
// How it works
// - Port 4 direction writes carry ones in bits 2-7, zeros in bits 0-1.
// - Port 6 direction writes carry ones in bits 4-7, zeros in bits 2-3.
// - Port 7 direction writes: ones in bits 6-7, zeros 1-5, bit 0 free.
// - Port 12 direction writes carry ones in bits 5-7, zeros in bits 3-4.
// - Port 14 direction writes carry ones in bits 1-7, zero in bit 0.
// - Port 2 latch resets zero; only bits 0-4 written, bits 5-7 zero.
// - Port 6 latch resets zero; only bits 0-1 written, rest zero.
// - Port 7 latch resets zero; only bit 0 written, rest zero.
// - Port 12 latch resets zero; only bits 0-2 written, rest zero.
// - Port 4 pull-up option resets zero and is always written zero.
// - Port 7 pull-up option resets zero; only bit 0 may be set.
// - Port 14 pull-up option resets zero and is always written zero.
// - Channel codes 0 to 4 select inputs; codes 5 to 7 are never sent.
// - Channel select resets zero; bits 3 to 7 always written zero.
// - Only the fourteen implemented device addresses are ever accessed.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "pcb_cfg.svh"

module pcb_host
   import pcb_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic [15:0] dev_addr,
   output logic [7:0] dev_wdata,
   output logic dev_we,
   output logic dev_re,
   input wire logic [7:0] dev_rdata
);

   function automatic pcb_desc_t desc(input logic [3:0] i);
      case (i)
         `PCB_I_P2L: desc = `PCB_R_P2L;
         `PCB_I_P6L: desc = `PCB_R_P6L;
         `PCB_I_P7L: desc = `PCB_R_P7L;
         `PCB_I_P12L: desc = `PCB_R_P12L;
         `PCB_I_PM2: desc = `PCB_R_PM2;
         `PCB_I_PM4: desc = `PCB_R_PM4;
         `PCB_I_PM6: desc = `PCB_R_PM6;
         `PCB_I_PM7: desc = `PCB_R_PM7;
         `PCB_I_ADS: desc = `PCB_R_ADS;
         `PCB_I_PORT12_DIRECTION: desc = `PCB_R_PORT12_DIRECTION;
         `PCB_I_PORT14_DIRECTION: desc = `PCB_R_PORT14_DIRECTION;
         `PCB_I_PU4: desc = `PCB_R_PU4;
         `PCB_I_PU7: desc = `PCB_R_PU7;
         `PCB_I_PORT14_PULLUP_OPTION: desc = `PCB_R_PORT14_PULLUP_OPTION;
         default: desc = `PCB_R_NONE;
      endcase
   endfunction : desc

   // Fixed ones forced, fixed zeros cleared, free bits from software
   function automatic logic [7:0] sanitize(input logic [3:0] i, input logic [7:0] v);
      pcb_desc_t d;
      d = desc(i);
      sanitize = d[`PCB_D_ONES] | (v & d[`PCB_D_WMSK]);
   endfunction : sanitize

   // Check a written byte against the fixed pattern of register i
   function automatic logic fits(input logic [3:0] i, input logic [7:0] v);
      pcb_desc_t d;
      d = desc(i);
      fits = ((v & d[`PCB_D_ONES]) == d[`PCB_D_ONES]) &&
             ((v & ~(d[`PCB_D_ONES] | d[`PCB_D_WMSK])) == 8'h00);
   endfunction : fits

   function automatic pcb_state_t init_state();
      pcb_state_t s;
      pcb_desc_t d;
      s = '0;
      s.fsm = PCB_IDLE;
      s.hreadyout = 1'b1;
      for (int k = 0; k < `PCB_NREG; k++) begin
         d = desc(k[3:0]);
         s.shadow[k] = d[`PCB_D_RST];
      end
      init_state = s;
   endfunction : init_state

   localparam pcb_state_t PCB_RST = init_state();

   pcb_state_t st;
   pcb_state_t next_st;

   logic aphase;
   logic launch;
   logic [3:0] lidx;
   logic lrd;
   logic idx_ok;
   logic code_ok;
   logic [3:0] widx;
   logic win_hit;
   pcb_desc_t ldesc;

   assign aphase = hsel && htrans[1] && hready;
   assign launch = st.dwr && (st.daddr == `PCB_A_CTRL);
   assign lidx = hwdata[`PCB_CMD_IDX];
   assign lrd = hwdata[`PCB_CMD_RD];
   assign idx_ok = lidx < `PCB_IDXW'(`PCB_NREG);
   assign code_ok = lrd || (lidx != `PCB_I_ADS) || (st.wbuf[`PCB_CODE] <= `PCB_MAX_CODE);
   assign widx = haddr[`PCB_IDX_HI:`PCB_IDX_LO];
   assign win_hit = (haddr[`PCB_WIN_HI:`PCB_WIN_LO] == `PCB_WIN_SEL) && (widx < `PCB_IDXW'(`PCB_NREG));
   assign ldesc = desc(lidx);

   always_comb begin
      next_st = st;
      next_st.dev_we = 1'b0;
      next_st.dev_re = 1'b0;
      next_st.hreadyout = 1'b1;

      // Bus side: latch address phase, answer reads with zero wait
      next_st.dwr = aphase && hwrite;
      if (aphase) begin
         next_st.daddr = haddr[7:0];
      end
      if (aphase && !hwrite) begin
         if (haddr[7:0] == `PCB_A_CTRL) begin
            next_st.hrdata = {23'h0, st.cmd};
         end else if (haddr[7:0] == `PCB_A_DATA) begin
            next_st.hrdata = {24'h000000, st.wbuf};
         end else if (haddr[7:0] == `PCB_A_STAT) begin
            next_st.hrdata = 32'h00000000;
            next_st.hrdata[`PCB_ST_BUSY] = (st.fsm != PCB_IDLE);
            next_st.hrdata[`PCB_ST_REJ] = st.rejected;
            next_st.hrdata[`PCB_ST_RD] = st.last_rd;
         end else if (win_hit) begin
            next_st.hrdata = {24'h000000, st.shadow[widx]};
         end else begin
            next_st.hrdata = 32'h00000000;
         end
      end
      if (st.dwr && (st.daddr == `PCB_A_DATA)) begin
         next_st.wbuf = hwdata[7:0];
      end

      case (st.fsm)
         PCB_IDLE: begin
            if (launch) begin
               next_st.cmd = hwdata[`PCB_CMD_W-1:0];
               if (idx_ok && code_ok) begin
                  next_st.rejected = 1'b0;
                  next_st.idx = lidx;
                  next_st.dev_addr = ldesc[`PCB_D_ADDR];
                  if (lrd) begin
                     next_st.dev_re = 1'b1;
                     next_st.fsm = PCB_RD;
                  end else begin
                     next_st.dev_wdata = sanitize(lidx, st.wbuf);
                     next_st.shadow[lidx] = sanitize(lidx, st.wbuf);
                     next_st.dev_we = 1'b1;
                     next_st.fsm = PCB_WR;
                  end
               end else begin
                  next_st.rejected = 1'b1;
               end
            end
         end
         PCB_WR: begin
            next_st.fsm = PCB_IDLE;
         end
         PCB_RD: begin
            next_st.fsm = PCB_CAP;
         end
         PCB_CAP: begin
            next_st.last_rd = dev_rdata;
            next_st.shadow[st.idx] = dev_rdata;
            next_st.fsm = PCB_IDLE;
         end
         default: begin
            next_st.fsm = PCB_IDLE;
         end
      endcase

      // Launch while busy is refused
      if (launch && (st.fsm != PCB_IDLE)) begin
         next_st.rejected = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= PCB_RST;
      end else begin
         st <= next_st;
      end
   end

   assign hreadyout = st.hreadyout;
   assign hresp = 1'b0;
   assign hrdata = st.hrdata;
   assign dev_addr = st.dev_addr;
   assign dev_wdata = st.dev_wdata;
   assign dev_we = st.dev_we;
   assign dev_re = st.dev_re;

   logic [7:0] ones_of_cur;
   pcb_desc_t cur_desc;
   assign cur_desc = desc(st.idx);
   assign ones_of_cur = cur_desc[`PCB_D_ONES];

   a_pm2_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we && st.idx == `PCB_I_PM2) |-> fits(`PCB_I_PM2, dev_wdata))
      else $error("port 2 direction write breaks fixed bits");
   a_pm4_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we && dev_addr == desc(`PCB_I_PM4) >> 24) |-> dev_wdata == ones_of_cur)
      else $error("port 4 direction write not at fixed pattern");
   a_pm6_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we && st.idx == `PCB_I_PM6) |-> fits(`PCB_I_PM6, dev_wdata))
      else $error("port 6 direction write breaks fixed bits");
   a_pm7_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we && st.idx == `PCB_I_PM7) |-> fits(`PCB_I_PM7, dev_wdata))
      else $error("port 7 direction write breaks fixed bits");
   a_port12_direction_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we && st.idx == `PCB_I_PORT12_DIRECTION) |-> fits(`PCB_I_PORT12_DIRECTION, dev_wdata))
      else $error("port 12 direction write breaks fixed bits");
   a_port14_direction_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we && st.idx == `PCB_I_PORT14_DIRECTION) |-> fits(`PCB_I_PORT14_DIRECTION, dev_wdata))
      else $error("port 14 direction write breaks fixed bits");
   a_p2_latch: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we && st.idx == `PCB_I_P2L) |-> fits(`PCB_I_P2L, dev_wdata))
      else $error("port 2 latch write sets reserved bits");
   a_p6_latch: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we && st.idx == `PCB_I_P6L) |-> fits(`PCB_I_P6L, dev_wdata))
      else $error("port 6 latch write sets reserved bits");
   a_p7_latch: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we && st.idx == `PCB_I_P7L) |-> fits(`PCB_I_P7L, dev_wdata))
      else $error("port 7 latch write sets reserved bits");
   a_p12_latch: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we && st.idx == `PCB_I_P12L) |-> fits(`PCB_I_P12L, dev_wdata))
      else $error("port 12 latch write sets reserved bits");
   a_pu4_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we && st.idx == `PCB_I_PU4) |-> dev_wdata == 8'h00)
      else $error("port 4 pull-up write not zero");
   a_pu7_bit0: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we && st.idx == `PCB_I_PU7) |-> fits(`PCB_I_PU7, dev_wdata))
      else $error("port 7 pull-up write sets reserved bits");
   a_port14_pullup_option_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we && st.idx == `PCB_I_PORT14_PULLUP_OPTION) |-> dev_wdata == 8'h00)
      else $error("port 14 pull-up write not zero");
   a_chan_code: assert property (@(posedge hclk) disable iff (!hresetn)
      (launch && st.fsm == PCB_IDLE && !lrd && lidx == `PCB_I_ADS && st.wbuf[`PCB_CODE] > `PCB_MAX_CODE)
      |=> (st.rejected && !dev_we) ##1 !dev_we)
      else $error("prohibited channel code reached the device");
   a_chan_upper: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we && st.idx == `PCB_I_ADS) |-> fits(`PCB_I_ADS, dev_wdata))
      else $error("channel select write sets upper bits");
   a_addr_valid: assert property (@(posedge hclk) disable iff (!hresetn)
      (dev_we || dev_re) |-> (st.idx < `PCB_IDXW'(`PCB_NREG)) && (dev_addr == desc(st.idx) >> 24))
      else $error("access to unimplemented device address");
   a_bad_index: assert property (@(posedge hclk) disable iff (!hresetn)
      (launch && st.fsm == PCB_IDLE && !idx_ok) |=> !dev_we && !dev_re && st.rejected)
      else $error("out of range index was not refused");
   a_shadow_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(dev_we) |-> st.shadow[st.idx] == dev_wdata ##1 st.fsm == PCB_IDLE)
      else $error("shadow copy differs from written value");
   a_read_capture: assert property (@(posedge hclk) disable iff (!hresetn)
      dev_re |=> st.fsm == PCB_CAP ##1 (st.last_rd == $past(dev_rdata) && st.fsm == PCB_IDLE))
      else $error("read data not captured one cycle after strobe");

endmodule : pcb_host

// ---- shared/pcb_cfg.svh ----
`ifndef PCB_CFG_SVH
`define PCB_CFG_SVH

`define PCB_NREG 14
`define PCB_IDXW 4
// Controller register byte offsets
`define PCB_A_CTRL 8'h00
`define PCB_A_DATA 8'h04
`define PCB_A_STAT 8'h08
`define PCB_WIN_SEL 2'h1
`define PCB_WIN_HI 7
`define PCB_WIN_LO 6
`define PCB_IDX_HI 5
`define PCB_IDX_LO 2
// Command word fields
`define PCB_CMD_IDX 3:0
`define PCB_CMD_RD 8
`define PCB_CMD_W 9
// Status word fields
`define PCB_ST_BUSY 0
`define PCB_ST_REJ 1
`define PCB_ST_RD 15:8
// Descriptor: device address, reset, fixed ones, writable bits
`define PCB_D_ADDR 39:24
`define PCB_D_RST 23:16
`define PCB_D_ONES 15:8
`define PCB_D_WMSK 7:0
`define PCB_CODE 2:0
`define PCB_MAX_CODE 3'h4
// Register indices
`define PCB_I_P2L 4'h0
`define PCB_I_P6L 4'h1
`define PCB_I_P7L 4'h2
`define PCB_I_P12L 4'h3
`define PCB_I_PM2 4'h4
`define PCB_I_PM4 4'h5
`define PCB_I_PM6 4'h6
`define PCB_I_PM7 4'h7
`define PCB_I_ADS 4'h8
`define PCB_I_PORT12_DIRECTION 4'h9
`define PCB_I_PORT14_DIRECTION 4'ha
`define PCB_I_PU4 4'hb
`define PCB_I_PU7 4'hc
`define PCB_I_PORT14_PULLUP_OPTION 4'hd
// Device register descriptors
`define PCB_R_P2L {16'hff02, 8'h00, 8'h00, 8'h1f}
`define PCB_R_P6L {16'hff06, 8'h00, 8'h00, 8'h03}
`define PCB_R_P7L {16'hff07, 8'h00, 8'h00, 8'h01}
`define PCB_R_P12L {16'hff0c, 8'h00, 8'h00, 8'h07}
`define PCB_R_PM2 {16'hff22, 8'hff, 8'he0, 8'h1f}
`define PCB_R_PM4 {16'hff24, 8'hff, 8'hfc, 8'h00}
`define PCB_R_PM6 {16'hff26, 8'hff, 8'hf0, 8'h03}
`define PCB_R_PM7 {16'hff27, 8'hff, 8'hc0, 8'h01}
`define PCB_R_ADS {16'hff29, 8'h00, 8'h00, 8'h07}
`define PCB_R_PORT12_DIRECTION {16'hff2c, 8'hff, 8'he0, 8'h07}
`define PCB_R_PORT14_DIRECTION {16'hff2e, 8'hff, 8'hfe, 8'h00}
`define PCB_R_PU4 {16'hff34, 8'h00, 8'h00, 8'h00}
`define PCB_R_PU7 {16'hff37, 8'h00, 8'h00, 8'h01}
`define PCB_R_PORT14_PULLUP_OPTION {16'hff3e, 8'h00, 8'h00, 8'h00}
`define PCB_R_NONE {16'h0000, 8'h00, 8'h00, 8'h00}

`endif

// ---- shared/pcb_pkg.sv ----
package pcb_pkg;
   typedef enum logic [3:0] {
      PCB_IDLE = 4'b0001,
      PCB_WR = 4'b0010,
      PCB_RD = 4'b0100,
      PCB_CAP = 4'b1000
   } pcb_fsm_t;

   typedef logic [39:0] pcb_desc_t;

   typedef struct packed {
      pcb_fsm_t fsm;
      logic hreadyout;
      logic [31:0] hrdata;
      logic dwr;
      logic [7:0] daddr;
      logic [7:0] wbuf;
      logic [8:0] cmd;
      logic [3:0] idx;
      logic [15:0] dev_addr;
      logic [7:0] dev_wdata;
      logic dev_we;
      logic dev_re;
      logic rejected;
      logic [7:0] last_rd;
      logic [13:0][7:0] shadow;
   } pcb_state_t;
endpackage : pcb_pkg

// ---- verification/pcb_dev_model.sv ----
`timescale 1ns/1ps
module pcb_dev_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [15:0] dev_addr,
   input wire logic [7:0] dev_wdata,
   input wire logic dev_we,
   input wire logic dev_re,
   output logic [7:0] dev_rdata,
   output logic [15:0] wr_cnt,
   output logic [15:0] err_cnt
);
   localparam logic [15:0] ADDR [14] = '{16'hff02, 16'hff06, 16'hff07, 16'hff0c, 16'hff22, 16'hff24, 16'hff26,
      16'hff27, 16'hff29, 16'hff2c, 16'hff2e, 16'hff34, 16'hff37, 16'hff3e};
   // Reset values, fixed ones and writable bits per slot
   localparam logic [7:0] RST [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff,
      8'hff, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] ONES [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'he0, 8'hfc, 8'hf0, 8'hc0, 8'h00, 8'he0,
      8'hfe, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] WM [14] = '{8'h1f, 8'h03, 8'h01, 8'h07, 8'h1f, 8'h00, 8'h03, 8'h01, 8'h07, 8'h07,
      8'h00, 8'h00, 8'h01, 8'h00};
   logic [7:0] regs [14];
   logic [7:0] rd_q;
   logic rd_v;

   function automatic int find(input logic [15:0] a);
      for (int i = 0; i < 14; i++) begin
         if (ADDR[i] === a) return i;
      end
      return -1;
   endfunction : find

   // Answer only in the cycle after the strobe, else show the inverse
   assign dev_rdata = rd_v ? rd_q : ~rd_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      int s;
      if (!hresetn) begin
         for (int i = 0; i < 14; i++) regs[i] <= RST[i];
         rd_q <= 8'h00;
         rd_v <= 1'b0;
         wr_cnt <= 16'h0000;
         err_cnt <= 16'h0000;
      end else begin
         rd_v <= 1'b0;
         if (dev_we || dev_re) begin
            s = find(dev_addr);
            if (s < 0) begin
               err_cnt <= err_cnt + 16'h0001;
            end else if (dev_we) begin
               wr_cnt <= wr_cnt + 16'h0001;
               if ((dev_wdata & ~WM[s]) !== ONES[s] || (s == 8 && dev_wdata[2:0] > 3'h4)) begin
                  err_cnt <= err_cnt + 16'h0001;
               end
               regs[s] <= ONES[s] | (dev_wdata & WM[s]);
            end else begin
               rd_q <= regs[s];
               rd_v <= 1'b1;
            end
         end
      end
   end
endmodule : pcb_dev_model

// ---- verification/port_config_register_bank_bench.sv ----
`timescale 1ns/1ps
module port_config_register_bank_bench;
   import pcb_pkg::*;
   localparam logic [15:0] ADDR [14] = '{16'hff02, 16'hff06, 16'hff07, 16'hff0c, 16'hff22, 16'hff24, 16'hff26,
      16'hff27, 16'hff29, 16'hff2c, 16'hff2e, 16'hff34, 16'hff37, 16'hff3e};
   localparam logic [7:0] RST [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff,
      8'hff, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] ONES [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'he0, 8'hfc, 8'hf0, 8'hc0, 8'h00, 8'he0,
      8'hfe, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] WM [14] = '{8'h1f, 8'h03, 8'h01, 8'h07, 8'h1f, 8'h00, 8'h03, 8'h01, 8'h07, 8'h07,
      8'h00, 8'h00, 8'h01, 8'h00};
   localparam logic [7:0] PAT [3] = '{8'hff, 8'h00, 8'ha5};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [15:0] dev_addr;
   logic [7:0] dev_wdata;
   logic dev_we;
   logic dev_re;
   logic [7:0] dev_rdata;
   logic [15:0] wr_cnt;
   logic [15:0] err_cnt;
   logic [31:0] st;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;

   assign hready = hreadyout;
   always #5 hclk = ~hclk;

   pcb_host u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_we(dev_we), .dev_re(dev_re), .dev_rdata(dev_rdata));
   pcb_dev_model u_dev (.hclk(hclk), .hresetn(hresetn), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
      .dev_we(dev_we), .dev_re(dev_re), .dev_rdata(dev_rdata), .wr_cnt(wr_cnt), .err_cnt(err_cnt));

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
         n_fail++;
      end
   endtask : chk

   // One single word transfer, entered just after a rising edge
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'b010;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask : ahb

   // Launch a device command, then poll status until idle
   task automatic op(input logic rd, input logic [3:0] idx);
      logic [31:0] r;
      ahb(1'b1, 32'h0, {23'h0, rd, 4'h0, idx}, r);
      for (int k = 0; k < 20; k++) begin
         ahb(1'b0, 32'h8, 32'h0, st);
         if (st[0] === 1'b0) break;
      end
   endtask : op

   task automatic wr_dev(input logic [3:0] idx, input logic [7:0] d);
      logic [31:0] r;
      ahb(1'b1, 32'h4, {24'h0, d}, r);
      op(1'b0, idx);
   endtask : wr_dev

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end

   initial begin
      logic [31:0] r;
      logic [7:0] e;
      logic [15:0] n0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 14; i++) begin
         ahb(1'b0, 32'h40 + 32'(4 * i), 32'h0, r);
         chk("shadow after reset", r, {24'h0, RST[i]});
         op(1'b1, 4'(i));
         chk("device after reset", {24'h0, st[15:8]}, {24'h0, RST[i]});
      end
      for (int i = 0; i < 14; i++) begin
         for (int p = 0; p < 3; p++) begin
            if (i == 8) continue;
            e = ONES[i] | (PAT[p] & WM[i]);
            wr_dev(4'(i), PAT[p]);
            chk("device address", {16'h0, dev_addr}, {16'h0, ADDR[i]});
            op(1'b1, 4'(i));
            chk("device readback", {24'h0, st[15:8]}, {24'h0, e});
            ahb(1'b0, 32'h40 + 32'(4 * i), 32'h0, r);
            chk("shadow readback", r, {24'h0, e});
         end
      end
      for (int c = 0; c < 8; c++) begin
         n0 = wr_cnt;
         wr_dev(4'h8, {5'h00, 3'(c)});
         chk("channel refused", {31'h0, st[1]}, {31'h0, c > 4});
         chk("channel strobes", {16'h0, wr_cnt - n0}, {31'h0, c <= 4});
         op(1'b1, 4'h8);
         chk("channel readback", {24'h0, st[15:8]}, (c > 4) ? 32'h4 : 32'(c));
      end
      n0 = wr_cnt;
      op(1'b0, 4'he);
      chk("index 14 refused", {31'h0, st[1]}, 32'h1);
      op(1'b1, 4'hf);
      chk("index 15 refused", {31'h0, st[1]}, 32'h1);
      chk("bad index strobes", {16'h0, wr_cnt}, {16'h0, n0});
      ahb(1'b1, 32'h0c, 32'hffffffff, r);
      ahb(1'b0, 32'h0c, 32'h0, r);
      chk("unmapped read", r, 32'h0);
      chk("bus response", {31'h0, hresp}, 32'h0);
      chk("device faults", {16'h0, err_cnt}, 32'h0);
      test_done();
   end
endmodule : port_config_register_bank_bench
